/* rtl/usr_consts.svh */
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by bare name from the package and the top module.
`ifndef USR_CONSTS_SVH
`define USR_CONSTS_SVH
`define USR_AW          12
`define USR_OFS_RXDATA  12'h119
`define USR_OFS_TXDATA  12'h11A
`define USR_OFS_DIV_LO  12'h11B
`define USR_OFS_DIV_HI  12'h11C
`define USR_OFS_RXCTL   12'h11D
`define USR_OFS_TXCTL   12'h11E
`define USR_OFS_BDCTL   12'h11F
`define USR_RC_PORT_EN  7
`define USR_RC_ADDR_DET 3
`define USR_TX_CLK_SRC  7
`define USR_TX_HIGH_SPD 2
`define USR_TX_EMPTY    1
`define USR_TX_NINTH    0
`define USR_BD_POL      4
`define USR_BD_WIDE     3
`define USR_BD_WAKE     1
`define USR_BD_AUTO     0
`define USR_RST_RC      5'h00
`define USR_RST_TX      7'h00
`define USR_RST_BD      4'h0
`define USR_RST_DIV     16'h0000
`define USR_RST_BYTE    8'h00
`define USR_RATIO_FAST  7'h04
`define USR_RATIO_MID   7'h10
`define USR_RATIO_SLOW  7'h40
`define USR_ABD_SH_FAST 4'h5
`define USR_ABD_SH_MID  4'h7
`define USR_ABD_SH_SLOW 4'h9
`define USR_ABD_FALLS   3'h4
`define USR_LEN_SYNC8   4'h8
`define USR_LEN_SYNC9   4'h9
`define USR_LEN_ASY8    4'hA
`define USR_LEN_ASY9    4'hB
`define USR_LEN_BREAK   4'hE
`define USR_FRAME_BREAK 14'h2000
`define USR_SHREG_IDLE  14'h3FFF
`endif

/* rtl/usr_pkg.sv */
// Types shared by the serial port register block.
// Assumes the constants header is on the include path.
`include "usr_consts.svh"
package usr_pkg;
	// Register port request
	typedef struct packed {
		logic [`USR_AW-1:0] addr;
		logic [7:0]         wdata;
		logic               wr;
		logic               rd;
	} usr_bus_t;

	typedef enum logic {
		USR_TX_IDLE  = 1'b0,
		USR_TX_SHIFT = 1'b1
	} usr_tx_st_t;

	typedef enum logic [1:0] {
		USR_RX_IDLE  = 2'b00,
		USR_RX_START = 2'b01,
		USR_RX_DATA  = 2'b11,
		USR_RX_STOP  = 2'b10
	} usr_rx_st_t;
endpackage

/* rtl/usr_top.sv */
// Serial port control, status and data registers with their shifters.
// Assumes pins synchronous to i_mclk and a one-cycle register port.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "usr_consts.svh"
module usr_top
	import usr_pkg::*;
(
	// Clock, reset, enable
	input  wire logic     i_mclk,
	input  wire logic     i_rstn,
	input  wire logic     i_ce,
	// Register port
	input  wire usr_bus_t i_bus,
	output logic [7:0]    o_rdata,
	// Clock / async transmit pin
	input  wire logic     i_ck,
	output logic          o_ck,
	output logic          o_ck_oe,
	// Data / async receive pin
	input  wire logic     i_dt,
	output logic          o_dt,
	output logic          o_dt_oe,
	// Receive interrupt flag
	output logic          o_rx_flag
);
	// =====================================================
	// Declarations
	logic        port_en_reg, rx_nine_reg, single_rx_reg, cont_rx_reg, addr_det_reg;
	logic        clk_src_reg, tx_nine_reg, tx_en_reg, sync_mode_reg, brk_req_reg;
	logic        high_spd_reg, tx_ninth_reg, pol_sel_reg, gen_wide_reg, wake_en_reg;
	logic        autobaud_en_reg, fram_err_reg, ovr_err_reg, rx_ninth_reg, abd_ovf_reg;
	logic        rx_full_reg, tx_full_reg, wake_reg, brk_reg, abd_run_reg;
	logic        ck_lvl_reg, ck_prev_reg, dt_prev_reg, lead_d_reg;
	logic [15:0] div_reg, bcnt_reg, div_eff, abd_div;
	logic [7:0]  rx_buf_reg, tx_buf_reg, rx_data;
	logic [13:0] shreg_reg, frame;
	logic [8:0]  rsr_reg;
	logic [3:0]  tbits_reg, rbits_reg, flen, nbits, abd_sh;
	logic [6:0]  tph_reg, rph_reg, ratio, half;
	logic [19:0] abd_cnt_reg, abd_q;
	logic [2:0]  abd_falls_reg;
	usr_tx_st_t  tx_st_reg;
	usr_rx_st_t  rx_st_reg;
	logic        prst, tick, dt_fall, lead, trail, m_act, tx_ok, tx_step, tx_end;
	logic        rx_mode, rx_step, rx_done, rx_accept, rx_ninth, fe, abd_done, abd_ok;
	logic        wr_rc, wr_tx, wr_bd, wr_dl, wr_dh, wr_td, rd_rx, rd_tx, cont_clr;
	logic        shift_empty, rx_idle, wake_hit, single_done;

	// =====================================================
	// Address decode
	assign wr_rc = i_bus.wr && (i_bus.addr == `USR_OFS_RXCTL);
	assign wr_tx = i_bus.wr && (i_bus.addr == `USR_OFS_TXCTL);
	assign wr_bd = i_bus.wr && (i_bus.addr == `USR_OFS_BDCTL);
	assign wr_dl = i_bus.wr && (i_bus.addr == `USR_OFS_DIV_LO);
	assign wr_dh = i_bus.wr && (i_bus.addr == `USR_OFS_DIV_HI);
	assign wr_td = i_bus.wr && (i_bus.addr == `USR_OFS_TXDATA);
	assign rd_rx = i_bus.rd && (i_bus.addr == `USR_OFS_RXDATA);
	assign rd_tx = i_bus.rd && (i_bus.addr == `USR_OFS_TXCTL);
	assign cont_clr = wr_rc && cont_rx_reg && !i_bus.wdata[`USR_RC_ADDR_DET+1];
	assign prst = !i_rstn || !port_en_reg;

	// =====================================================
	// Control registers; write wins over hardware clear
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			{port_en_reg, rx_nine_reg, single_rx_reg, cont_rx_reg, addr_det_reg} <= `USR_RST_RC;
			{clk_src_reg, tx_nine_reg, tx_en_reg, sync_mode_reg, brk_req_reg, high_spd_reg,
				tx_ninth_reg} <= `USR_RST_TX;
			{pol_sel_reg, gen_wide_reg, wake_en_reg, autobaud_en_reg} <= `USR_RST_BD;
			div_reg <= `USR_RST_DIV;
		end
		else if (i_ce)
		begin
			if (single_done)
				single_rx_reg <= 1'b0;
			if (tx_end && brk_reg)
				brk_req_reg <= 1'b0;
			if (wake_hit)
				wake_en_reg <= 1'b0;
			if (abd_done)
				autobaud_en_reg <= 1'b0;
			if (abd_ok)
				div_reg <= abd_div;
			if (wr_rc)
				{port_en_reg, rx_nine_reg, single_rx_reg, cont_rx_reg, addr_det_reg}
					<= i_bus.wdata[`USR_RC_PORT_EN:`USR_RC_ADDR_DET];
			if (wr_tx)
			begin
				{clk_src_reg, tx_nine_reg, tx_en_reg, sync_mode_reg, brk_req_reg, high_spd_reg}
					<= i_bus.wdata[`USR_TX_CLK_SRC:`USR_TX_HIGH_SPD];
				tx_ninth_reg <= i_bus.wdata[`USR_TX_NINTH];
			end
			if (wr_bd)
			begin
				{pol_sel_reg, gen_wide_reg} <= i_bus.wdata[`USR_BD_POL:`USR_BD_WIDE];
				{wake_en_reg, autobaud_en_reg} <= i_bus.wdata[`USR_BD_WAKE:`USR_BD_AUTO];
			end
			if (wr_dl)
				div_reg[7:0] <= i_bus.wdata;
			if (wr_dh)
				div_reg[15:8] <= i_bus.wdata;
		end
	end

	// =====================================================
	// Baud generator and bit period
	assign div_eff = gen_wide_reg ? div_reg : {8'h00, div_reg[7:0]};
	assign tick = (bcnt_reg == 16'h0000);
	always_ff @(posedge i_mclk)
	begin
		if (prst)
			bcnt_reg <= `USR_RST_DIV;
		else if (i_ce)
			bcnt_reg <= tick ? div_eff : bcnt_reg - 16'h0001;
	end

	always_comb
	begin
		ratio = `USR_RATIO_SLOW;
		abd_sh = `USR_ABD_SH_SLOW;
		if (high_spd_reg && gen_wide_reg)
		begin
			ratio = `USR_RATIO_FAST;
			abd_sh = `USR_ABD_SH_FAST;
		end
		else if (high_spd_reg || gen_wide_reg)
		begin
			ratio = `USR_RATIO_MID;
			abd_sh = `USR_ABD_SH_MID;
		end
	end
	assign half = {1'b0, ratio[6:1]};

	// =====================================================
	// Sync clock: master generates, slave follows the pin
	assign m_act = sync_mode_reg && clk_src_reg
		&& (tx_st_reg == USR_TX_SHIFT || rx_st_reg == USR_RX_DATA);
	assign lead = clk_src_reg ? (tick && m_act && ck_lvl_reg == pol_sel_reg)
		: (ck_prev_reg == pol_sel_reg && i_ck != pol_sel_reg);
	assign trail = clk_src_reg ? (tick && m_act && ck_lvl_reg != pol_sel_reg)
		: (ck_prev_reg != pol_sel_reg && i_ck == pol_sel_reg);
	assign dt_fall = dt_prev_reg && !i_dt;
	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			ck_lvl_reg <= 1'b0;
			ck_prev_reg <= 1'b0;
			dt_prev_reg <= 1'b1;
			lead_d_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			// Pin clock lags the level by one flop; data follows it
			lead_d_reg <= lead;
			ck_prev_reg <= i_ck;
			dt_prev_reg <= i_dt;
			if (!m_act)
				ck_lvl_reg <= pol_sel_reg;
			else if (tick)
				ck_lvl_reg <= !ck_lvl_reg;
		end
	end

	// =====================================================
	// Transmitter
	assign tx_ok = tx_en_reg && !(sync_mode_reg && (single_rx_reg || cont_rx_reg));
	assign tx_step = sync_mode_reg ? trail : (tick && tph_reg == ratio - 7'h01);
	assign tx_end = i_ce && tx_st_reg == USR_TX_SHIFT && tx_step && tbits_reg == 4'h1;
	assign shift_empty = (tx_st_reg == USR_TX_IDLE);
	always_comb
	begin
		frame = {5'h1F, tx_buf_reg, 1'b0};
		flen = `USR_LEN_ASY8;
		if (sync_mode_reg)
		begin
			frame = {5'h00, tx_nine_reg && tx_ninth_reg, tx_buf_reg};
			flen = tx_nine_reg ? `USR_LEN_SYNC9 : `USR_LEN_SYNC8;
		end
		else if (brk_req_reg)
		begin
			frame = `USR_FRAME_BREAK;
			flen = `USR_LEN_BREAK;
		end
		else if (tx_nine_reg)
		begin
			frame = {4'hF, tx_ninth_reg, tx_buf_reg, 1'b0};
			flen = `USR_LEN_ASY9;
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			tx_st_reg <= USR_TX_IDLE;
			shreg_reg <= `USR_SHREG_IDLE;
			tbits_reg <= 4'h0;
			tph_reg <= 7'h00;
			brk_reg <= 1'b0;
		end
		else if (i_ce)
		begin
			case (tx_st_reg)
				USR_TX_IDLE:
				begin
					if (tx_full_reg && tx_ok)
					begin
						tx_st_reg <= USR_TX_SHIFT;
						shreg_reg <= frame;
						tbits_reg <= flen;
						tph_reg <= 7'h00;
						brk_reg <= !sync_mode_reg && brk_req_reg;
					end
				end
				USR_TX_SHIFT:
				begin
					if (tx_step)
					begin
						tph_reg <= 7'h00;
						shreg_reg <= {1'b1, shreg_reg[13:1]};
						tbits_reg <= tbits_reg - 4'h1;
						if (tbits_reg == 4'h1)
							tx_st_reg <= USR_TX_IDLE;
					end
					else if (!sync_mode_reg && tick)
						tph_reg <= tph_reg + 7'h01;
				end
				default:
					tx_st_reg <= USR_TX_IDLE;
			endcase
		end
	end

	// Holding register; a new write beats the load-out clear
	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			tx_full_reg <= 1'b0;
			tx_buf_reg <= `USR_RST_BYTE;
		end
		else if (i_ce)
		begin
			if (tx_st_reg == USR_TX_IDLE && tx_ok)
				tx_full_reg <= 1'b0;
			if (wr_td)
			begin
				tx_full_reg <= 1'b1;
				tx_buf_reg <= i_bus.wdata;
			end
		end
	end

	// =====================================================
	// Receiver
	assign rx_mode = sync_mode_reg ? (cont_rx_reg || (single_rx_reg && clk_src_reg))
		: (cont_rx_reg && !wake_en_reg && !autobaud_en_reg);
	assign nbits = rx_nine_reg ? `USR_LEN_SYNC9 : `USR_LEN_SYNC8;
	assign rx_step = sync_mode_reg ? trail : (tick && rph_reg == ratio - 7'h01);
	assign rx_done = i_ce && rx_mode && rx_st_reg == USR_RX_STOP && (sync_mode_reg || rx_step);
	assign single_done = rx_done && sync_mode_reg && clk_src_reg && !cont_rx_reg;
	assign rx_data = rx_nine_reg ? rsr_reg[7:0] : rsr_reg[8:1];
	assign rx_ninth = rx_nine_reg && rsr_reg[8];
	assign fe = !sync_mode_reg && !i_dt;
	assign rx_accept = sync_mode_reg || !rx_nine_reg || !addr_det_reg || rx_ninth;
	assign rx_idle = (rx_st_reg == USR_RX_IDLE);
	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			rx_st_reg <= USR_RX_IDLE;
			rsr_reg <= 9'h000;
			rbits_reg <= 4'h0;
			rph_reg <= 7'h00;
		end
		else if (i_ce)
		begin
			if (!rx_mode)
				rx_st_reg <= USR_RX_IDLE;
			else
				case (rx_st_reg)
					USR_RX_IDLE:
					begin
						rph_reg <= 7'h00;
						rbits_reg <= 4'h0;
						if (sync_mode_reg)
							rx_st_reg <= USR_RX_DATA;
						else if (dt_fall)
							rx_st_reg <= USR_RX_START;
					end
					USR_RX_START:
					begin
						if (tick && rph_reg == half - 7'h01)
						begin
							rph_reg <= 7'h00;
							rx_st_reg <= i_dt ? USR_RX_IDLE : USR_RX_DATA;
						end
						else if (tick)
							rph_reg <= rph_reg + 7'h01;
					end
					USR_RX_DATA:
					begin
						if (rx_step)
						begin
							rph_reg <= 7'h00;
							rsr_reg <= {i_dt, rsr_reg[8:1]};
							rbits_reg <= rbits_reg + 4'h1;
							if (rbits_reg == nbits - 4'h1)
								rx_st_reg <= USR_RX_STOP;
						end
						else if (!sync_mode_reg && tick)
							rph_reg <= rph_reg + 7'h01;
					end
					USR_RX_STOP:
					begin
						if (rx_done)
						begin
							rbits_reg <= 4'h0;
							rx_st_reg <= sync_mode_reg ? USR_RX_DATA : USR_RX_IDLE;
						end
						else if (tick)
							rph_reg <= rph_reg + 7'h01;
					end
					default:
						rx_st_reg <= USR_RX_IDLE;
				endcase
		end
	end

	// Receive buffer and error flags; hardware set beats clear
	assign wake_hit = i_ce && !sync_mode_reg && wake_en_reg && dt_fall;
	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			{rx_full_reg, fram_err_reg, ovr_err_reg, rx_ninth_reg, wake_reg} <= `USR_RST_RC;
			rx_buf_reg <= `USR_RST_BYTE;
		end
		else if (i_ce)
		begin
			if (rd_rx)
			begin
				rx_full_reg <= 1'b0;
				fram_err_reg <= 1'b0;
				wake_reg <= 1'b0;
			end
			if (cont_clr)
				ovr_err_reg <= 1'b0;
			if (rx_done && rx_accept)
			begin
				if (rx_full_reg && !rd_rx)
					ovr_err_reg <= 1'b1;
				else
				begin
					rx_full_reg <= 1'b1;
					rx_buf_reg <= rx_data;
					fram_err_reg <= fe;
					rx_ninth_reg <= rx_ninth;
				end
			end
			if (wake_hit)
				wake_reg <= 1'b1;
		end
	end

	// =====================================================
	// Auto-baud: clocks over eight bit times of a sync character
	assign abd_q = abd_cnt_reg >> abd_sh;
	assign abd_div = abd_q[15:0] - 16'h0001;
	assign abd_done = i_ce && abd_run_reg
		&& ((&abd_cnt_reg) || (dt_fall && abd_falls_reg == `USR_ABD_FALLS - 3'h1));
	assign abd_ok = abd_done && !(&abd_cnt_reg);
	always_ff @(posedge i_mclk)
	begin
		if (prst)
		begin
			abd_run_reg <= 1'b0;
			abd_ovf_reg <= 1'b0;
			abd_cnt_reg <= 20'h00000;
			abd_falls_reg <= 3'h0;
		end
		else if (i_ce)
		begin
			if (!abd_run_reg)
			begin
				if (!sync_mode_reg && autobaud_en_reg && dt_fall)
				begin
					abd_run_reg <= 1'b1;
					abd_ovf_reg <= 1'b0;
					abd_cnt_reg <= 20'h00001;
					abd_falls_reg <= 3'h0;
				end
			end
			else if (&abd_cnt_reg)
			begin
				abd_run_reg <= 1'b0;
				abd_ovf_reg <= 1'b1;
			end
			else
			begin
				abd_cnt_reg <= abd_cnt_reg + 20'h00001;
				if (dt_fall)
					abd_falls_reg <= abd_falls_reg + 3'h1;
				if (abd_done)
					abd_run_reg <= 1'b0;
			end
		end
	end

	// =====================================================
	// Read data and pins
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			o_rdata <= `USR_RST_BYTE;
			o_ck <= 1'b1;
			o_ck_oe <= 1'b0;
			o_dt <= 1'b1;
			o_dt_oe <= 1'b0;
			o_rx_flag <= 1'b0;
		end
		else if (i_ce)
		begin
			o_rdata <= `USR_RST_BYTE;
			if (i_bus.rd)
				case (i_bus.addr)
					`USR_OFS_RXDATA: o_rdata <= rx_buf_reg;
					`USR_OFS_TXDATA: o_rdata <= tx_buf_reg;
					`USR_OFS_DIV_LO: o_rdata <= div_reg[7:0];
					`USR_OFS_DIV_HI: o_rdata <= div_reg[15:8];
					`USR_OFS_RXCTL: o_rdata <= {port_en_reg, rx_nine_reg, single_rx_reg,
						cont_rx_reg, addr_det_reg, fram_err_reg, ovr_err_reg, rx_ninth_reg};
					`USR_OFS_TXCTL: o_rdata <= {clk_src_reg, tx_nine_reg, tx_en_reg,
						sync_mode_reg, brk_req_reg, high_spd_reg, shift_empty, tx_ninth_reg};
					`USR_OFS_BDCTL: o_rdata <= {abd_ovf_reg, rx_idle, 1'b0, pol_sel_reg,
						gen_wide_reg, 1'b0, wake_en_reg, autobaud_en_reg};
					default: o_rdata <= `USR_RST_BYTE;
				endcase
			o_ck_oe <= port_en_reg && (sync_mode_reg ? clk_src_reg : tx_en_reg);
			o_ck <= sync_mode_reg ? ck_lvl_reg
				: (((tx_st_reg == USR_TX_SHIFT) ? shreg_reg[0] : 1'b1) ^ pol_sel_reg);
			o_dt_oe <= port_en_reg && sync_mode_reg && tx_ok;
			if (lead_d_reg)
				o_dt <= shreg_reg[0];
			o_rx_flag <= rx_full_reg || wake_reg;
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	property p_pen_off;
		!port_en_reg |=> rx_st_reg == USR_RX_IDLE && shift_empty && !rx_full_reg && !ovr_err_reg;
	endproperty
	a_pen_off: assert property (p_pen_off) else $error("port not held off");
	property p_empty_rd;
		rd_tx && i_ce |=> o_rdata[`USR_TX_EMPTY] == $past(shift_empty);
	endproperty
	a_empty_rd: assert property (p_empty_rd) else $error("shift empty misread");
	property p_ovr_hold;
		ovr_err_reg && port_en_reg && !cont_clr |=> ovr_err_reg;
	endproperty
	a_ovr_hold: assert property (p_ovr_hold) else $error("overrun lost");
	property p_addr_det;
		rx_done && !sync_mode_reg && rx_nine_reg && addr_det_reg && !rx_ninth
			&& !rx_full_reg |=> !rx_full_reg;
	endproperty
	a_addr_det: assert property (p_addr_det) else $error("data char accepted");
	property p_single;
		single_done && !wr_rc |=> !single_rx_reg;
	endproperty
	a_single: assert property (p_single) else $error("single receive stuck");
	property p_tx_prio;
		sync_mode_reg && (single_rx_reg || cont_rx_reg) && shift_empty |=> shift_empty;
	endproperty
	a_tx_prio: assert property (p_tx_prio) else $error("sent while receiving");
	property p_break;
		i_ce && shift_empty && tx_full_reg && tx_ok && !sync_mode_reg && brk_req_reg
			|=> tbits_reg == `USR_LEN_BREAK && shreg_reg == `USR_FRAME_BREAK;
	endproperty
	a_break: assert property (p_break) else $error("break frame wrong");
	property p_wake;
		wake_hit |=> wake_reg && !wake_en_reg;
	endproperty
	a_wake: assert property (p_wake) else $error("wake-up missed");
	property p_ratio;
		high_spd_reg && gen_wide_reg |-> ratio == `USR_RATIO_FAST;
	endproperty
	a_ratio: assert property (p_ratio) else $error("fast ratio wrong");
	c_break: cover property (tx_end && brk_reg);
	c_wake: cover property (wake_hit ##1 o_rx_flag);
	c_sync_word: cover property (rx_done && sync_mode_reg && clk_src_reg);
	c_abd: cover property (abd_ok);
endmodule // usr_top
`default_nettype wire

/* verif/usr_peer.sv */
// Remote serial peer: sends asynchronous frames, decodes asynchronous and sync ones.
// Assumes the caller enters each task right after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module usr_peer (
	// Clock
	input  wire logic i_mclk,
	// Line from the device, line to the device
	input  wire logic i_line,
	output logic      o_line,
	// Synchronous clock and data from the device
	input  wire logic i_sck,
	input  wire logic i_sdt
);
	// =========================================
	// Transmit side, idles high like a pull-up
	initial o_line = 1'b1;

	task automatic send(input logic [8:0] v, input int n, input logic s, input int p);
		o_line <= 1'b0;
		repeat (p) @(posedge i_mclk);
		for (int i = 0; i < n; i++)
		begin
			o_line <= v[i];
			repeat (p) @(posedge i_mclk);
		end
		o_line <= s;
		repeat (p) @(posedge i_mclk);
		o_line <= 1'b1;
		repeat (p) @(posedge i_mclk);
	endtask

	// =========================================
	// Receive side, samples mid-bit
	task automatic recv(output logic [8:0] v, input int n, input int p);
		int k;
		v = '0;
		k = 0;
		while (i_line !== 1'b0 && k < 4000)
		begin
			@(posedge i_mclk);
			k++;
		end
		repeat (p / 2) @(posedge i_mclk);
		for (int i = 0; i < n; i++)
		begin
			repeat (p) @(posedge i_mclk);
			v[i] = i_line;
		end
		repeat (p) @(posedge i_mclk);
	endtask

	// =========================================
	// Sync receive, samples data on the edge back to idle
	task automatic recv_sync(output logic [8:0] v, input int n, input logic idle);
		int k;
		v = '0;
		k = 0;
		for (int i = 0; i < n; i++)
		begin
			while (i_sck === idle && k < 4000)
			begin
				@(posedge i_mclk);
				k++;
			end
			while (i_sck !== idle && k < 4000)
			begin
				@(posedge i_mclk);
				k++;
			end
			v[i] = i_sdt;
		end
	endtask
endmodule // usr_peer
`default_nettype wire

/* verif/usart_control_status_regs_tb.sv */
// Self-checking bench for the serial port register block.
// Assumes usr_pkg and usr_top compiled first; divisor 0 for speed.
`timescale 1ns/100ps
`default_nettype none
module usart_control_status_regs_tb;
	import usr_pkg::*;
	logic       i_mclk;
	logic       i_rstn;
	logic       ce;
	usr_bus_t   bus;
	logic [7:0] o_rdata;
	logic       o_ck;
	logic       o_ck_oe;
	logic       dt;
	logic       o_dt;
	logic       o_dt_oe;
	logic       o_rx_flag;
	logic [8:0] v;
	int         num_errors;
	int         n_tests;

	usr_top i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_ce(ce), .i_bus(bus),
		.o_rdata(o_rdata), .i_ck(1'b0), .o_ck(o_ck), .o_ck_oe(o_ck_oe), .i_dt(dt),
		.o_dt(o_dt), .o_dt_oe(o_dt_oe), .o_rx_flag(o_rx_flag));
	usr_peer i_peer (.i_mclk(i_mclk), .i_line(o_ck), .o_line(dt), .i_sck(o_ck),
		.i_sdt(o_dt));

	initial i_mclk = 1'b0;
	always #5 i_mclk = ~i_mclk;

	// =========================================
	// Checks and bus cycles
	task automatic complete_run();
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp(input string nm, input logic [8:0] e, input logic [8:0] s);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("FAIL %s exp %h got %h", nm, e, s);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge i_mclk);
		bus.wr <= 1'b0;
		@(posedge i_mclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge i_mclk);
		bus.rd <= 1'b0;
		#1;
		cmp("register", {1'b0, e}, {1'b0, o_rdata});
		@(posedge i_mclk);
	endtask

	task automatic wait_flag();
		int k;
		k = 0;
		while (o_rx_flag !== 1'b1 && k < 200)
		begin
			@(posedge i_mclk);
			k++;
		end
		cmp("rx flag", 9'h001, 9'(o_rx_flag));
		if (k == 200)
			complete_run();
	endtask

	// Hang guard
	initial
	begin
		repeat (100000) @(posedge i_mclk);
		num_errors++;
		complete_run();
	end

	// =========================================
	// Main sequence
	initial
	begin
		num_errors = 0;
		n_tests = 0;
		bus = '0;
		ce = 1'b1;
		i_rstn = 1'b0;
		repeat (6) @(posedge i_mclk);
		i_rstn <= 1'b1;
		@(posedge i_mclk);
		rd(12'h11D, 8'h00);
		rd(12'h11E, 8'h02);
		rd(12'h120, 8'h00);
		ce <= 1'b0;
		wr(12'h11B, 8'hFF);
		ce <= 1'b1;
		rd(12'h11B, 8'h00);
		wr(12'h11B, 8'h5A);
		wr(12'h11C, 8'hA5);
		rd(12'h11B, 8'h5A);
		rd(12'h11C, 8'hA5);
		wr(12'h11B, 8'h00);
		wr(12'h11C, 8'h00);
		wr(12'h11E, 8'h24);
		wr(12'h11A, 8'h77);
		repeat (8) @(posedge i_mclk);
		rd(12'h11E, 8'h26);
		wr(12'h11F, 8'h08);
		wr(12'h11D, 8'h90);
		repeat (60) @(posedge i_mclk);
		cmp("tx idle", 9'h001, 9'(o_ck));
		fork
			i_peer.recv(v, 8, 4);
			begin
				wr(12'h11A, 8'hA5);
				repeat (3) @(posedge i_mclk);
				rd(12'h11E, 8'h24);
			end
		join
		cmp("tx char", 9'h0A5, v);
		rd(12'h11E, 8'h26);
		wr(12'h11E, 8'h65);
		fork
			i_peer.recv(v, 9, 4);
			wr(12'h11A, 8'h3C);
		join
		cmp("tx char", 9'h13C, v);
		wr(12'h11E, 8'h2C);
		wr(12'h11A, 8'h00);
		repeat (80) @(posedge i_mclk);
		rd(12'h11E, 8'h26);
		wr(12'h11F, 8'h18);
		repeat (3) @(posedge i_mclk);
		cmp("tx idle", 9'h000, 9'(o_ck));
		wr(12'h11F, 8'h08);
		fork
			i_peer.send(9'h096, 8, 1'b1, 4);
			begin
				repeat (12) @(posedge i_mclk);
				rd(12'h11F, 8'h08);
			end
		join
		wait_flag();
		rd(12'h11D, 8'h90);
		rd(12'h119, 8'h96);
		rd(12'h11F, 8'h48);
		cmp("rx flag", 9'h000, 9'(o_rx_flag));
		wr(12'h11D, 8'hD0);
		i_peer.send(9'h14B, 9, 1'b1, 4);
		rd(12'h11D, 8'hD1);
		rd(12'h119, 8'h4B);
		wr(12'h11D, 8'hD8);
		i_peer.send(9'h011, 9, 1'b1, 4);
		cmp("rx flag", 9'h000, 9'(o_rx_flag));
		i_peer.send(9'h122, 9, 1'b1, 4);
		rd(12'h119, 8'h22);
		wr(12'h11D, 8'h90);
		i_peer.send(9'h055, 8, 1'b0, 4);
		rd(12'h11D, 8'h94);
		rd(12'h119, 8'h55);
		rd(12'h11D, 8'h90);
		i_peer.send(9'h011, 8, 1'b1, 4);
		i_peer.send(9'h022, 8, 1'b1, 4);
		rd(12'h11D, 8'h92);
		wr(12'h11D, 8'h90);
		rd(12'h11D, 8'h92);
		rd(12'h119, 8'h11);
		wr(12'h11D, 8'h80);
		rd(12'h11D, 8'h80);
		wr(12'h11D, 8'h90);
		wr(12'h11F, 8'h0A);
		fork
			i_peer.send(9'h0FF, 8, 1'b1, 4);
			wait_flag();
		join
		rd(12'h11F, 8'h48);
		wr(12'h11F, 8'h09);
		i_peer.send(9'h055, 8, 1'b1, 36);
		rd(12'h11F, 8'h48);
		rd(12'h11B, 8'h08);
		wr(12'h11B, 8'h00);
		wr(12'h11E, 8'hB0);
		wr(12'h11D, 8'hA0);
		repeat (4) @(posedge i_mclk);
		cmp("clock drive", 9'h001, 9'(o_ck_oe));
		cmp("data drive", 9'h000, 9'(o_dt_oe));
		repeat (60) @(posedge i_mclk);
		rd(12'h11D, 8'h80);
		rd(12'h119, 8'hFF);
		wr(12'h11D, 8'h80);
		fork
			i_peer.recv_sync(v, 8, 1'b0);
			wr(12'h11A, 8'hC3);
		join
		cmp("sync char", 9'h0C3, v);
		complete_run();
	end
endmodule // usart_control_status_regs_tb
`default_nettype wire
